// >>> acc_shifter.sv
// Purpose: zero-fill shift of the accumulator with carry-out detection
// Assumes: count of 1 to 15; count 0 passes the value through with no carry
// Notes:   a double-width window catches every bit that falls off the end
`timescale 1ns/1ps
module acc_shifter
	import plc_logic_pkg::*;
(
	alu_link_if.shifter link
);

	logic [2*ACC_W-1:0] wide;

	always_comb begin
		if (link.toward_msb) begin
			wide             = {ACC_ZERO, link.acc} << link.count;
			link.shifted     = wide[ACC_W-1:0];
			link.shift_carry = |wide[2*ACC_W-1:ACC_W];
		end else begin
			wide             = {link.acc, ACC_ZERO} >> link.count;
			link.shifted     = wide[2*ACC_W-1:ACC_W];
			link.shift_carry = |wide[ACC_W-1:0];
		end
	end

endmodule

// >>> alu_link_if.sv
// Purpose: carries operands and results between the core and its helpers
// Assumes: purely combinational helpers on the same clock
// Notes:   one modport per party
`timescale 1ns/1ps
interface alu_link_if;
	import plc_logic_pkg::*;

	acc_t   acc;
	count_t count;
	logic   toward_msb;
	acc_t   shifted;
	logic   shift_carry;
	acc_t   binary;
	logic   digit_bad;

	modport core    (output acc, output count, output toward_msb,
	                 input shifted, input shift_carry, input binary, input digit_bad);
	modport shifter (input acc, input count, input toward_msb,
	                 output shifted, output shift_carry);
	modport conv    (input acc, output binary, output digit_bad);
endinterface

// >>> alu_unit_properties.sv
// Purpose: port-level checks of the accumulator logic unit
// Assumes: one clock, async active-low reset
// Notes:   fault cases are left to the bench model
`timescale 1ns/1ps
module alu_unit_properties (
	input wire logic        ref_clk_in,
	input wire logic        rst_n_in,
	input wire logic        start_in,
	input wire logic        rung_in,
	input wire logic [3:0]  op_code_in,
	input wire logic [3:0]  shift_count_in,
	input wire logic [15:0] operand_in,
	input wire logic [15:0] acc_out,
	input wire logic        carry_out,
	input wire logic        zero_out,
	input wire logic        done_out,
	input wire logic        fault_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic tk = start_in && rung_in;
	property p_or; tk && op_code_in == 4'h1 |=> acc_out == ($past(acc_out) | $past(operand_in)); endproperty
	a_or: assert property (p_or) else $error("or result wrong");
	property p_zero; done_out && !fault_out |-> zero_out == (acc_out == 16'h0000); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_shl; tk && op_code_in == 4'h3 |=> acc_out == $past(acc_out) << $past(shift_count_in); endproperty
	a_shl: assert property (p_shl) else $error("left shift wrong");
	property p_shr; tk && op_code_in == 4'h2 |=> acc_out == $past(acc_out) >> $past(shift_count_in); endproperty
	a_shr: assert property (p_shr) else $error("right shift wrong");
	property p_cy; tk && op_code_in == 4'h2 |=>
		carry_out == |($past(acc_out) & ~(16'hFFFF << $past(shift_count_in))); endproperty
	a_cy: assert property (p_cy) else $error("carry wrong");
	property p_cyl; tk && op_code_in == 4'h3 |=>
		carry_out == |($past(acc_out) & ~(16'hFFFF >> $past(shift_count_in))); endproperty
	a_cyl: assert property (p_cyl) else $error("left carry wrong");
	property p_enc; tk && op_code_in == 4'h5 |=> acc_out[15:4] == 12'h000; endproperty
	a_enc: assert property (p_enc) else $error("encode upper bits not clear");
	property p_dec; tk && op_code_in == 4'h4 |=> acc_out == 16'h0001 << $past(acc_out[3:0]); endproperty
	a_dec: assert property (p_dec) else $error("decode wrong");
	property p_inv; tk && op_code_in == 4'h6 |=> acc_out == ~$past(acc_out); endproperty
	a_inv: assert property (p_inv) else $error("invert wrong");
	property p_done; done_out == $past(tk); endproperty
	a_done: assert property (p_done) else $error("done timing wrong");
	c_carry: cover property (tk && op_code_in == 4'h3 ##1 carry_out);
	c_fault: cover property (fault_out);
	c_refused: cover property (start_in && !rung_in);
endmodule

// >>> bcd_converter.sv
// Purpose: packed four-digit decimal to unsigned binary
// Assumes: each nibble holds one digit, most significant digit on top
// Notes:   a nibble above nine is still weighted as is and flagged
`timescale 1ns/1ps
module bcd_converter
	import plc_logic_pkg::*;
(
	alu_link_if.conv link
);

	function automatic acc_t digit(input acc_t v, input int pos);
		digit = (v >> (pos * NIB_W)) & acc_t'({NIB_W{1'h1}});
	endfunction

	always_comb begin
		link.binary = acc_t'(digit(link.acc, 3) * W_THOUSANDS)
		            + acc_t'(digit(link.acc, 2) * W_HUNDREDS)
		            + acc_t'(digit(link.acc, 1) * W_TENS)
		            + digit(link.acc, 0);
		link.digit_bad = 1'b0;
		for (int i = 0; i < DIGITS; i++) begin
			if (digit(link.acc, i) > acc_t'(DIGIT_MAX)) begin
				link.digit_bad = 1'b1;
			end
		end
	end

endmodule

// >>> plc_accumulator_logic_unit.sv
// Purpose: logic operations on a 16-bit controller accumulator
// Assumes: issuer on the same clock; opcode and count valid with start
// Notes:   each operation finishes in the cycle it is taken
//
// Contract
// - or operand into accumulator, store result
// - zero flag after or when zero
// - shift toward msb 1-15, zero fill
// - shift toward lsb 1-15, zero fill
// - carry set when a one leaves
// - zero flag after shift when zero
// - decode low nibble to one-hot bit
// - decode ignores upper twelve bits
// - encode lowest set bit to index
// - encode clears upper twelve bits
// - invert complements all sixteen bits
// - packed decimal replaced by binary value
`timescale 1ns/1ps
module plc_accumulator_logic_unit
	import plc_logic_pkg::*;
(
	input  wire logic         ref_clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         start_in,
	input  wire logic         rung_in,
	input  wire logic [3:0]   op_code_in,
	input  wire logic [3:0]   shift_count_in,
	input  wire logic [15:0]  operand_in,
	output logic      [15:0]  acc_out,
	output logic              carry_out,
	output logic              zero_out,
	output logic              done_out,
	output logic              fault_out
);

	// ********************************
	// helper functions
	// ********************************
	function automatic acc_t one_hot(input logic [NIB_W-1:0] idx);
		one_hot = ACC_ONE << idx;
	endfunction

	function automatic acc_t lowest_index(input acc_t v);
		lowest_index = ACC_ZERO;
		for (int i = ACC_W - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest_index = acc_t'(i);
			end
		end
	endfunction

	function automatic logic is_zero(input acc_t v);
		is_zero = (v == ACC_ZERO);
	endfunction

	// ********************************
	// state
	// ********************************
	acc_t acc_q;
	acc_t acc_d;
	logic carry_q;
	logic carry_d;
	logic zero_q;
	logic zero_d;
	logic done_q;
	logic done_d;
	logic fault_q;
	logic fault_d;
	logic take;
	op_e  op;

	alu_link_if link ();

	// ********************************
	// helpers
	// ********************************
	acc_shifter u_shifter (
		.link (link.shifter)
	);

	bcd_converter u_conv (
		.link (link.conv)
	);

	assign link.acc        = acc_q;
	assign link.count      = shift_count_in;
	assign link.toward_msb = (op_code_in == shift_toward_msb_op);

	// ********************************
	// next state
	// ********************************
	// the rung gate is kept here too, so a stray start never changes state
	assign take = start_in & rung_in;
	assign op   = op_e'(op_code_in);

	// one select per operation, one for both shifts, decoded once and shared by every state group but done
	typedef struct packed {
		logic load;
		logic merge;
		logic shift;
		logic decode;
		logic encode;
		logic invert;
		logic convert;
		logic legal;
	} op_sel_s;

	op_sel_s sel;

	always_comb begin
		sel.load    = 1'h0;
		sel.merge   = 1'h0;
		sel.shift   = 1'h0;
		sel.decode  = 1'h0;
		sel.encode  = 1'h0;
		sel.invert  = 1'h0;
		sel.convert = 1'h0;
		sel.legal   = 1'h0;
		case (op)
			load_op: begin
				sel.load  = 1'h1;
				sel.legal = 1'h1;
			end
			or_op: begin
				sel.merge = 1'h1;
				sel.legal = 1'h1;
			end
			shift_toward_lsb_op,
			shift_toward_msb_op: begin
				sel.shift = 1'h1;
				sel.legal = 1'h1;
			end
			decode_op: begin
				sel.decode = 1'h1;
				sel.legal  = 1'h1;
			end
			encode_op: begin
				sel.encode = 1'h1;
				sel.legal  = 1'h1;
			end
			invert_op: begin
				sel.invert = 1'h1;
				sel.legal  = 1'h1;
			end
			decimal_to_binary_op: begin
				sel.convert = 1'h1;
				sel.legal   = 1'h1;
			end
			default: begin
				// codes eight to fifteen select nothing and report a fault
				sel.legal = 1'h0;
			end
		endcase
	end

	// ********************************
	// operation results
	// ********************************
	acc_t or_result;
	acc_t decode_result;
	acc_t encode_result;
	acc_t invert_result;

	assign or_result     = acc_q | operand_in;
	// only the low nibble reaches the decoder
	assign decode_result = one_hot(acc_q[NIB_W-1:0]);
	// an index never exceeds fifteen, so the upper twelve bits stay clear
	assign encode_result = lowest_index(acc_q);
	assign invert_result = ~acc_q;

	// ********************************
	// fault reasons
	// ********************************
	logic count_bad;
	logic code_bad;
	logic digit_fault;

	// a zero count is outside the legal range; the shift then flags a fault, keeps the value and clears carry
	assign count_bad   = sel.shift & (shift_count_in == SHIFT_NONE);
	assign code_bad    = ~sel.legal;
	// a nibble above nine is still converted, weighted as it stands
	assign digit_fault = sel.convert & link.digit_bad;

	// ********************************
	// accumulator
	// ********************************
	always_comb begin
		acc_d = acc_q;
		if (take) begin
			if (sel.load) begin
				acc_d = operand_in;
			end else if (sel.merge) begin
				acc_d = or_result;
			end else if (sel.shift) begin
				// a zero count passes the value through unchanged
				acc_d = link.shifted;
			end else if (sel.decode) begin
				acc_d = decode_result;
			end else if (sel.encode) begin
				acc_d = encode_result;
			end else if (sel.invert) begin
				acc_d = invert_result;
			end else if (sel.convert) begin
				acc_d = link.binary;
			end else begin
				// an illegal code keeps the accumulator as it was
				acc_d = acc_q;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_q <= ACC_RESET;
		end else begin
			acc_q <= acc_d;
		end
	end

	// ********************************
	// carry flag
	// ********************************
	// only the shifts touch carry; every other operation leaves it standing
	always_comb begin
		carry_d = carry_q;
		if (take && sel.shift) begin
			carry_d = link.shift_carry;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			carry_q <= 1'h0;
		end else begin
			carry_q <= carry_d;
		end
	end

	// ********************************
	// zero flag
	// ********************************
	// taken from the next accumulator value on each legal code; reset clears the flag while the accumulator is zero
	always_comb begin
		zero_d = zero_q;
		if (take && sel.legal) begin
			zero_d = is_zero(acc_d);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			zero_q <= 1'h0;
		end else begin
			zero_q <= zero_d;
		end
	end

	// ********************************
	// done pulse
	// ********************************
	// every taken request answers once, illegal codes included
	always_comb begin
		done_d = 1'h0;
		if (take) begin
			done_d = 1'h1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_q <= 1'h0;
		end else begin
			done_q <= done_d;
		end
	end

	// ********************************
	// fault pulse
	// ********************************
	// fault is a report only; it never blocks the result of a legal code
	always_comb begin
		fault_d = 1'h0;
		if (take) begin
			fault_d = code_bad | count_bad | digit_fault;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_q <= 1'h0;
		end else begin
			fault_q <= fault_d;
		end
	end

	// ********************************
	// outputs
	// ********************************
	// every output is a register, so the issuer never sees a decode glitch
	assign acc_out   = acc_q;
	assign carry_out = carry_q;
	assign zero_out  = zero_q;
	assign done_out  = done_q;
	assign fault_out = fault_q;

endmodule

// >>> plc_logic_pkg.sv
// Purpose: shared constants and types for the accumulator logic unit
// Assumes: 16-bit accumulator, 4-digit packed decimal operands
// Notes:   shared widths, the accumulator reset value and the digit weights live here; the unit resets its flags to zero itself
package plc_logic_pkg;

	// ********************************
	// widths
	// ********************************
	localparam int ACC_W     = 16;
	localparam int CNT_W     = 4;
	localparam int NIB_W     = 4;
	localparam int DIGITS    = 4;
	localparam int IDX_W     = 4;

	typedef logic [ACC_W-1:0] acc_t;
	typedef logic [CNT_W-1:0] count_t;

	// ********************************
	// reset values and limits
	// ********************************
	localparam acc_t   ACC_RESET   = 16'h0000;
	localparam acc_t   ACC_ZERO    = 16'h0000;
	localparam acc_t   ACC_ONE     = 16'h0001;
	localparam count_t SHIFT_NONE  = 4'h0;
	localparam logic [NIB_W-1:0] DIGIT_MAX = 4'h9;

	// ********************************
	// decimal digit weights
	// ********************************
	localparam acc_t W_TENS      = 16'h000A;
	localparam acc_t W_HUNDREDS  = 16'h0064;
	localparam acc_t W_THOUSANDS = 16'h03E8;

	// ********************************
	// operation codes
	// ********************************
	typedef enum logic [3:0] {
		load_op              = 4'h0,
		or_op                = 4'h1,
		shift_toward_lsb_op  = 4'h2,
		shift_toward_msb_op  = 4'h3,
		decode_op            = 4'h4,
		encode_op            = 4'h5,
		invert_op            = 4'h6,
		decimal_to_binary_op = 4'h7
	} op_e;

endpackage

// >>> rung_issuer.sv
// Purpose: instruction issuer, one request per call
// Assumes: drives 1 ns after the rising edge
// Notes:   released fields show inverted values so stale data never passes
`timescale 1ns/1ps
module rung_issuer (
	input  wire logic   ref_clk_in,
	output logic        start_out,
	output logic        rung_out,
	output logic [3:0]  op_out,
	output logic [3:0]  count_out,
	output logic [15:0] operand_out
);
	initial {start_out, rung_out, op_out, count_out, operand_out} = '0;
	task automatic issue(input logic [3:0] o, input logic [3:0] c, input logic [15:0] d,
		input logic r);
		@(posedge ref_clk_in);
		#1;
		{start_out, rung_out, op_out, count_out, operand_out} = {1'b1, r, o, c, d};
		@(posedge ref_clk_in);
		#1;
		{start_out, rung_out, op_out, count_out, operand_out} = {1'b0, ~r, ~o, ~c, ~d};
	endtask
endmodule

// >>> testbench.sv
// Purpose: random self-checking run against an integer model
// Assumes: issuer spaces requests one idle cycle apart
// Notes:   includes a reset in mid-run
`timescale 1ns/1ps
module testbench;
	import plc_logic_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        st, rg, cy_o, z_o, dn_o, ft_o;
	logic [3:0]  op, cn;
	logic [15:0] od, acc_o, v;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          m_acc = 0;
	int          m_cy = 0;
	int          m_z = 0;
	initial forever #20 clk = ~clk;
	rung_issuer iss (.ref_clk_in(clk), .start_out(st), .rung_out(rg), .op_out(op),
		.count_out(cn), .operand_out(od));
	plc_accumulator_logic_unit dut (.ref_clk_in(clk), .rst_n_in(rst_n), .start_in(st),
		.rung_in(rg), .op_code_in(op), .shift_count_in(cn), .operand_in(od), .acc_out(acc_o),
		.carry_out(cy_o), .zero_out(z_o), .done_out(dn_o), .fault_out(ft_o));
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic run(input int o, input int c, input int d, input bit r);
		int e;
		int f;
		int y;
		e = m_acc;
		f = 0;
		y = m_cy;
		case (o)
			0: e = d;
			1: e = m_acc | d;
			2: e = m_acc >> c;
			3: e = (m_acc << c) & 65535;
			4: e = 1 << (m_acc & 15);
			5: begin
				e = 0;
				for (int k = 15; k >= 0; k--) if (m_acc[k]) e = k;
			end
			6: e = ~m_acc & 65535;
			7: begin
				e = 0;
				for (int k = 12; k >= 0; k -= 4) begin
					e = e * 10 + ((m_acc >> k) & 15);
					f |= ((m_acc >> k) & 15) > 9;
				end
			end
			default: f = 1;
		endcase
		if (o == 2 || o == 3) begin
			y = (o == 2) ? (m_acc & ((1 << c) - 1)) != 0 : (m_acc >> (16 - c)) != 0;
			f = c == 0;
		end
		if (r && o < 8) begin
			m_acc = e;
			m_z = e == 0;
			m_cy = y;
		end
		iss.issue(4'(o), 4'(c), 16'(d), r);
		check("acc", acc_o, 16'(m_acc));
		check("carry", 16'(cy_o), 16'(m_cy));
		check("zero", 16'(z_o), 16'(m_z));
		check("done", 16'(dn_o), 16'(r));
		check("fault", 16'(ft_o), 16'(r && f));
	endtask
	initial begin
		void'($urandom(1));
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 80; i++) begin
			v = 16'($urandom);
			if (i % 4 != 3) for (int k = 0; k < 16; k += 4) v[k+:4] = v[k+:4] % 10;
			run(0, 0, (i % 9 == 0) ? 0 : v, 1);
			run(i % 10, (i % 16 == 1) ? 15 : $urandom % 16, $urandom % 65536, $urandom % 5 != 0);
		end
		rst_n = 1'b0;
		@(posedge clk);
		#1;
		{m_acc, m_cy, m_z} = '0;
		check("reset acc", acc_o, 16'h0000);
		check("reset flags", 16'({cy_o, z_o, dn_o, ft_o}), 16'h0000);
		rst_n = 1'b1;
		run(0, 0, 16'h8001, 1);
		run(3, 1, 0, 1);
		run(2, 2, 0, 1);
		end_of_test();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			bad_count++;
			end_of_test();
		end
	end
endmodule
bind plc_accumulator_logic_unit alu_unit_properties chk (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .start_in(start_in), .rung_in(rung_in), .op_code_in(op_code_in),
	.shift_count_in(shift_count_in), .operand_in(operand_in), .acc_out(acc_out),
	.carry_out(carry_out), .zero_out(zero_out), .done_out(done_out), .fault_out(fault_out));
